// *** src/amp_pkg.sv ***
// constants shared by both ends of the amplifier control link
// assumes a 100 MHz system clock on both ends
package amp_pkg;
  localparam int CLK_PERIOD_NS = 10;
  localparam int SCL_MAX_KHZ = 400;
  localparam int SCL_MIN_PERIOD_NS = 1000000 / SCL_MAX_KHZ;
  // half period rounded up so the bus never runs faster than its limit
  localparam int SCL_HALF_CYC = (SCL_MIN_PERIOD_NS + 2 * CLK_PERIOD_NS - 1) / (2 * CLK_PERIOD_NS);
  localparam int DIV_W = 16;
  localparam int BYTE_BITS = 8;
  localparam int CNT_W = 4;
  localparam logic [CNT_W-1:0] ACK_SLOT = 4'h8;
  localparam logic [BYTE_BITS-1:0] DEV_ADDR = 8'hde;
  localparam int SEL_POS = 7;
  localparam int PAYLOAD_W = 7;
  localparam logic SEL_MODE = 1'b0;
  localparam logic SEL_GAIN = 1'b1;
  localparam int POWER_POS = 0;
  localparam int MUTE_POS = 1;
  localparam int TEST_POS = 4;
  localparam int GAIN_W = 6;
  localparam logic [PAYLOAD_W-1:0] MODE_RESET = 7'h00;
  localparam logic [PAYLOAD_W-1:0] GAIN_RESET = 7'h00;
  localparam logic [GAIN_W-1:0] GAIN_MUTE_CODE = 6'h00;
endpackage

// *** src/amp_if.sv ***
// two-wire link between the bus master and the amplifier slave
// open drain data line: a party pulls low when its enable is high
interface amp_if;
  logic scl;
  logic sda_m_out;
  logic sda_m_oe;
  logic sda_s_out;
  logic sda_s_oe;
  logic sda;

  // wired-and with pull-up; only low drives count
  assign sda = !((sda_m_oe && !sda_m_out) || (sda_s_oe && !sda_s_out));

  modport master (output scl, output sda_m_out, output sda_m_oe, input sda);
  modport slave (input scl, input sda, output sda_s_out, output sda_s_oe);
endinterface

// *** src/amp_sync.sv ***
// two-flop synchroniser with one extra stage for edge detection
// assumes idle-high lines, so the flops reset to one
module amp_sync #(
  parameter int W = 2
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q,
  output logic [W-1:0] q_prev
);
  logic [W-1:0] meta_r;
  logic [W-1:0] meta_nxt;
  logic [W-1:0] sync_r;
  logic [W-1:0] sync_nxt;
  logic [W-1:0] prev_r;
  logic [W-1:0] prev_nxt;

  always_comb begin
    meta_nxt = d;
    sync_nxt = meta_r;
    prev_nxt = sync_r;
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      meta_r <= '1;
      sync_r <= '1;
      prev_r <= '1;
    end else begin
      meta_r <= meta_nxt;
      sync_r <= sync_nxt;
      prev_r <= prev_nxt;
    end
  end

  assign q = sync_r;
  assign q_prev = prev_r;
endmodule // amp_sync

// *** src/amp_slave.sv ***
// write-only serial slave holding the amplifier mode and gain registers
// assumes scl and sda arrive asynchronously from an external master

// Function
// - bus clock at most 400kHz, both ends
// - master alone drives the serial clock
// - data stable while clock high, except framing
// - data falling under high clock starts transaction
// - eight bits then one acknowledge pulse
// - respond only to full byte 11011110
// - master sends address msb first, write zero
// - read request gets no acknowledge
// - address bits sampled on clock rise
// - matching address acknowledged low on ninth pulse
// - data top bit selects mode or gain
// - every data byte is acknowledged
// - unlimited data bytes per transaction
// - data rising under high clock ends transaction
// - mode bit0 power, bit1 mute, default zero
// - software writes zero to test, unused bits
// - gain register low six bits, default zero
// - gain code zero means muted output
// - after stop ignore bus until addressed
module amp_slave (
  input wire logic clk,
  input wire logic rst_b,
  amp_if.slave bus,
  output logic power_active_bit,
  output logic output_mute,
  output logic factory_test_bit,
  output logic [amp_pkg::GAIN_W-1:0] gain_code,
  output logic output_muted,
  output logic selected,
  output logic byte_applied
);
  typedef enum {
    S_IDLE,
    S_ADDR,
    S_ACK,
    S_DATA,
    S_IGNORE
  } amp_slave_e;

  amp_slave_e state_r;
  amp_slave_e state_nxt;
  logic [amp_pkg::CNT_W-1:0] cnt_r;
  logic [amp_pkg::CNT_W-1:0] cnt_nxt;
  logic [amp_pkg::BYTE_BITS-1:0] shift_r;
  logic [amp_pkg::BYTE_BITS-1:0] shift_nxt;
  logic ack_r;
  logic ack_nxt;
  logic sda_out_r;
  logic [amp_pkg::PAYLOAD_W-1:0] mode_r;
  logic [amp_pkg::PAYLOAD_W-1:0] mode_nxt;
  logic [amp_pkg::PAYLOAD_W-1:0] gain_r;
  logic [amp_pkg::PAYLOAD_W-1:0] gain_nxt;
  logic muted_r;
  logic muted_nxt;
  logic selected_r;
  logic selected_nxt;
  logic applied_r;
  logic applied_nxt;
  logic [1:0] pins_q;
  logic [1:0] pins_prev;
  logic scl_s;
  logic sda_s;
  logic scl_p;
  logic sda_p;
  logic scl_rise;
  logic scl_fall;
  logic start_seen;
  logic stop_seen;

  // both lines share one synchroniser so their relative order survives
  amp_sync #(
    .W(2)
  ) u_sync (
    .clk(clk),
    .rst_b(rst_b),
    .d({bus.scl, bus.sda}),
    .q(pins_q),
    .q_prev(pins_prev)
  );

  assign scl_s = pins_q[1];
  assign sda_s = pins_q[0];
  assign scl_p = pins_prev[1];
  assign sda_p = pins_prev[0];
  // the clock is only ever observed here, never driven
  assign scl_rise = scl_s && !scl_p;
  assign scl_fall = !scl_s && scl_p;
  // data edges with the clock held high both before and after are framing
  assign start_seen = scl_s && scl_p && sda_p && !sda_s;
  assign stop_seen = scl_s && scl_p && !sda_p && sda_s;

  always_comb begin
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    shift_nxt = shift_r;
    ack_nxt = ack_r;
    mode_nxt = mode_r;
    gain_nxt = gain_r;
    selected_nxt = selected_r;
    applied_nxt = 1'b0;
    if (start_seen) begin
      // a start also restarts a transaction already under way
      state_nxt = S_ADDR;
      cnt_nxt = '0;
      ack_nxt = 1'b0;
      selected_nxt = 1'b0;
    end else if (stop_seen) begin
      state_nxt = S_IDLE;
      ack_nxt = 1'b0;
      selected_nxt = 1'b0;
    end else begin
      case (state_r)
        S_ADDR, S_DATA: begin
          if (scl_rise && cnt_r != amp_pkg::ACK_SLOT) begin
            // data only changes while scl is low, so the rise is a safe sample point
            shift_nxt = {shift_r[amp_pkg::BYTE_BITS-2:0], sda_s};
            cnt_nxt = cnt_r + 4'h1;
          end else if (scl_fall && cnt_r == amp_pkg::ACK_SLOT) begin
            cnt_nxt = '0;
            if (state_r == S_ADDR) begin
              // direction bit is part of the compare, so reads never match
              if (shift_r == amp_pkg::DEV_ADDR) begin
                ack_nxt = 1'b1;
                state_nxt = S_ACK;
                selected_nxt = 1'b1;
              end else begin
                state_nxt = S_IGNORE;
              end
            end else begin
              if (shift_r[amp_pkg::SEL_POS] == amp_pkg::SEL_GAIN) begin
                gain_nxt = shift_r[amp_pkg::PAYLOAD_W-1:0];
              end else begin
                // test and unused bits are stored as written; keeping them zero is software's job
                mode_nxt = shift_r[amp_pkg::PAYLOAD_W-1:0];
              end
              applied_nxt = 1'b1;
              ack_nxt = 1'b1;
              state_nxt = S_ACK;
            end
          end
        end
        S_ACK: begin
          // hold the line low for the whole ninth pulse, release on its fall
          if (scl_fall) begin
            ack_nxt = 1'b0;
            state_nxt = S_DATA;
          end
        end
        S_IDLE, S_IGNORE: begin
          ack_nxt = 1'b0;
        end
        default: begin
          state_nxt = S_IDLE;
          ack_nxt = 1'b0;
        end
      endcase
    end
    muted_nxt = mode_nxt[amp_pkg::MUTE_POS] || (gain_nxt[amp_pkg::GAIN_W-1:0] == amp_pkg::GAIN_MUTE_CODE);
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      state_r <= S_IDLE;
      cnt_r <= '0;
      shift_r <= '0;
      ack_r <= 1'b0;
      sda_out_r <= 1'b0;
      mode_r <= amp_pkg::MODE_RESET;
      gain_r <= amp_pkg::GAIN_RESET;
      muted_r <= 1'b1;
      selected_r <= 1'b0;
      applied_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      shift_r <= shift_nxt;
      ack_r <= ack_nxt;
      sda_out_r <= 1'b0;
      mode_r <= mode_nxt;
      gain_r <= gain_nxt;
      muted_r <= muted_nxt;
      selected_r <= selected_nxt;
      applied_r <= applied_nxt;
    end
  end

  // logic runs at 100 MHz, far above the fastest legal bus clock
  assign bus.sda_s_oe = ack_r;
  assign bus.sda_s_out = sda_out_r;
  assign power_active_bit = mode_r[amp_pkg::POWER_POS];
  assign output_mute = mode_r[amp_pkg::MUTE_POS];
  assign factory_test_bit = mode_r[amp_pkg::TEST_POS];
  assign gain_code = gain_r[amp_pkg::GAIN_W-1:0];
  assign output_muted = muted_r;
  assign selected = selected_r;
  assign byte_applied = applied_r;
endmodule // amp_slave

// *** src/amp_master.sv ***
// bus master end: sends address then a stream of register bytes
// assumes a user that hands over one byte at a time with a last flag
module amp_master #(
  parameter int HALF_CYC = amp_pkg::SCL_HALF_CYC,
  parameter logic [amp_pkg::BYTE_BITS-1:0] ADDR_BYTE = amp_pkg::DEV_ADDR
) (
  input wire logic clk,
  input wire logic rst_b,
  amp_if.master bus,
  input wire logic cmd_valid,
  input wire logic [amp_pkg::BYTE_BITS-1:0] cmd_data,
  input wire logic cmd_last,
  output logic cmd_ready,
  output logic done,
  output logic nack
);
  typedef enum {
    M_IDLE,
    M_START,
    M_LOW,
    M_HIGH,
    M_WAIT,
    M_STOP1,
    M_STOP2,
    M_STOP3
  } amp_master_e;

  amp_master_e state_r;
  amp_master_e state_nxt;
  logic [amp_pkg::DIV_W-1:0] div_r;
  logic [amp_pkg::DIV_W-1:0] div_nxt;
  logic [amp_pkg::CNT_W-1:0] cnt_r;
  logic [amp_pkg::CNT_W-1:0] cnt_nxt;
  logic [amp_pkg::BYTE_BITS-1:0] shift_r;
  logic [amp_pkg::BYTE_BITS-1:0] shift_nxt;
  logic [amp_pkg::BYTE_BITS-1:0] data_r;
  logic [amp_pkg::BYTE_BITS-1:0] data_nxt;
  logic is_addr_r, is_addr_nxt, more_r, more_nxt;
  logic scl_r, scl_nxt, oe_r, oe_nxt, sda_out_r;
  logic ready_r, ready_nxt, done_r, done_nxt, nack_r, nack_nxt;
  logic [1:0] pins_q;
  logic tick;
  logic take;

  amp_sync #(
    .W(2)
  ) u_sync (
    .clk(clk),
    .rst_b(rst_b),
    .d({bus.sda, 1'b1}),
    .q(pins_q),
    .q_prev()
  );

  assign tick = div_r == amp_pkg::DIV_W'(HALF_CYC - 1);
  assign take = cmd_valid && ready_r;

  always_comb begin
    state_nxt = state_r;
    div_nxt = tick ? '0 : div_r + 16'h0001;
    cnt_nxt = cnt_r;
    shift_nxt = shift_r;
    data_nxt = data_r;
    is_addr_nxt = is_addr_r;
    more_nxt = more_r;
    scl_nxt = scl_r;
    oe_nxt = oe_r;
    ready_nxt = ready_r;
    done_nxt = 1'b0;
    nack_nxt = nack_r;
    case (state_r)
      M_IDLE: begin
        div_nxt = '0;
        scl_nxt = 1'b1;
        oe_nxt = 1'b0;
        if (take) begin
          shift_nxt = ADDR_BYTE;
          data_nxt = cmd_data;
          more_nxt = !cmd_last;
          is_addr_nxt = 1'b1;
          ready_nxt = 1'b0;
          nack_nxt = 1'b0;
          oe_nxt = 1'b1;
          state_nxt = M_START;
        end
      end
      M_START: if (tick) begin
        scl_nxt = 1'b0;
        cnt_nxt = '0;
        state_nxt = M_LOW;
      end
      M_LOW: begin
        // data only moves while the clock is low
        oe_nxt = (cnt_r != amp_pkg::ACK_SLOT) && !shift_r[amp_pkg::BYTE_BITS-1];
        if (tick) begin
          scl_nxt = 1'b1;
          state_nxt = M_HIGH;
        end
      end
      M_HIGH: if (tick) begin
        scl_nxt = 1'b0;
        if (cnt_r != amp_pkg::ACK_SLOT) begin
          shift_nxt = {shift_r[amp_pkg::BYTE_BITS-2:0], 1'b0};
          cnt_nxt = cnt_r + 4'h1;
          state_nxt = M_LOW;
        end else if (pins_q[1]) begin
          nack_nxt = 1'b1;
          state_nxt = M_STOP1;
        end else if (is_addr_r) begin
          shift_nxt = data_r;
          is_addr_nxt = 1'b0;
          cnt_nxt = '0;
          state_nxt = M_LOW;
        end else if (more_r) begin
          ready_nxt = 1'b1;
          state_nxt = M_WAIT;
        end else begin
          state_nxt = M_STOP1;
        end
      end
      M_WAIT: begin
        // clock parked low while the user has no byte ready
        div_nxt = '0;
        oe_nxt = 1'b0;
        if (take) begin
          shift_nxt = cmd_data;
          more_nxt = !cmd_last;
          ready_nxt = 1'b0;
          cnt_nxt = '0;
          state_nxt = M_LOW;
        end
      end
      M_STOP1: begin
        oe_nxt = 1'b1;
        if (tick) begin
          scl_nxt = 1'b1;
          state_nxt = M_STOP2;
        end
      end
      M_STOP2: if (tick) begin
        oe_nxt = 1'b0;
        state_nxt = M_STOP3;
      end
      M_STOP3: if (tick) begin
        done_nxt = 1'b1;
        ready_nxt = 1'b1;
        state_nxt = M_IDLE;
      end
      default: state_nxt = M_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      state_r <= M_IDLE;
      div_r <= '0;
      cnt_r <= '0;
      shift_r <= '0;
      data_r <= '0;
      is_addr_r <= 1'b0;
      more_r <= 1'b0;
      scl_r <= 1'b1;
      oe_r <= 1'b0;
      sda_out_r <= 1'b0;
      ready_r <= 1'b1;
      done_r <= 1'b0;
      nack_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      div_r <= div_nxt;
      cnt_r <= cnt_nxt;
      shift_r <= shift_nxt;
      data_r <= data_nxt;
      is_addr_r <= is_addr_nxt;
      more_r <= more_nxt;
      scl_r <= scl_nxt;
      oe_r <= oe_nxt;
      sda_out_r <= 1'b0;
      ready_r <= ready_nxt;
      done_r <= done_nxt;
      nack_r <= nack_nxt;
    end
  end

  assign bus.scl = scl_r;
  assign bus.sda_m_oe = oe_r;
  assign bus.sda_m_out = sda_out_r;
  assign cmd_ready = ready_r;
  assign done = done_r;
  assign nack = nack_r;
endmodule // amp_master

// *** dv/amp_link_properties.sv ***
// checker on the link between master and slave ends
// assumes all link signals are sampled on the shared system clock
module amp_link_chk (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic scl,
  input wire logic sda_m_out,
  input wire logic sda_m_oe,
  input wire logic sda_s_out,
  input wire logic sda_s_oe,
  input wire logic sda
);
  // start to first clock fall takes one half period; allow two
  localparam int START_MAX = 2 * amp_pkg::SCL_HALF_CYC;
  localparam logic [15:0] HALF_MIN = 16'(amp_pkg::SCL_HALF_CYC);
  logic scl_last_r;
  logic sda_last_r;
  // samples the clock has held its current level, saturating
  logic [15:0] run_r;
  logic [15:0] run_nxt;
  logic [3:0] rise_cnt_r;
  logic [3:0] rise_cnt_nxt;
  logic start_seen;
  logic stop_seen;
  logic scl_rise;
  assign start_seen = scl && scl_last_r && sda_last_r && !sda;
  assign stop_seen = scl && scl_last_r && !sda_last_r && sda;
  assign scl_rise = scl && !scl_last_r;
  // counts clock rises within a byte slot, ninth rise wraps to zero
  always_comb begin
    run_nxt = (scl != scl_last_r) ? 16'h0001 : ((run_r == 16'hffff) ? run_r : run_r + 16'h0001);
    rise_cnt_nxt = rise_cnt_r;
    if (start_seen) begin
      rise_cnt_nxt = 4'h0;
    end else if (scl_rise) begin
      rise_cnt_nxt = (rise_cnt_r == 4'h8) ? 4'h0 : rise_cnt_r + 4'h1;
    end
  end
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      scl_last_r <= 1'b1;
      sda_last_r <= 1'b1;
      rise_cnt_r <= 4'h0;
      run_r <= 16'hffff;
    end else begin
      scl_last_r <= scl;
      sda_last_r <= sda;
      rise_cnt_r <= rise_cnt_nxt;
      run_r <= run_nxt;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  property p_scl_high_min;
    scl_last_r && !scl |-> run_r >= HALF_MIN;
  endproperty
  a_scl_high_min: assert property (p_scl_high_min) else $error("clock high too short");
  property p_scl_low_min;
    !scl_last_r && scl |-> run_r >= HALF_MIN;
  endproperty
  a_scl_low_min: assert property (p_scl_low_min) else $error("clock low too short");
  property p_ack_at_ninth;
    $rose(sda_s_oe) |-> !scl && rise_cnt_r == 4'h8;
  endproperty
  a_ack_at_ninth: assert property (p_ack_at_ninth) else $error("ack not after eighth bit");
  property p_ack_stands;
    $rose(sda_s_oe) |-> sda_s_oe [*8];
  endproperty
  a_ack_stands: assert property (p_ack_stands) else $error("ack dropped early");
  property p_ack_release;
    $fell(sda_s_oe) |-> !scl && rise_cnt_r == 4'h0;
  endproperty
  a_ack_release: assert property (p_ack_release) else $error("ack released off slot");
  property p_ack_wins;
    sda_s_oe && scl |-> !sda_m_oe && !sda;
  endproperty
  a_ack_wins: assert property (p_ack_wins) else $error("ack slot not low");
  property p_open_drain;
    sda_m_oe || sda_s_oe |-> !sda_m_out && !sda_s_out && !sda;
  endproperty
  a_open_drain: assert property (p_open_drain) else $error("driven line not low");
  property p_frame_only;
    $changed(sda_m_oe) && scl && scl_last_r |-> !sda_s_oe;
  endproperty
  a_frame_only: assert property (p_frame_only) else $error("data moved in ack");
  property p_start_clock;
    start_seen |-> ##[1:START_MAX] !scl;
  endproperty
  a_start_clock: assert property (p_start_clock) else $error("no clock after start");
  property p_stop_after_ack;
    stop_seen |-> rise_cnt_r == 4'h1 && !sda_s_oe;
  endproperty
  a_stop_after_ack: assert property (p_stop_after_ack) else $error("stop misplaced");
endmodule // amp_link_chk

// *** dv/test_amp_ctrl_i2c_write_slave.sv ***
// bench: two master/slave pairs, the second master sends the read bit
// assumes package, interface and both design ends compiled first
module test_amp_ctrl_i2c_write_slave;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0;
  logic rst_b;
  logic [1:0] cmd_valid = 2'b00;
  logic [7:0] cmd_data = 8'h00;
  logic cmd_last = 1'b0;
  logic [1:0] rdy, done, nack, pwr, mute, tst, muted, sel, appl;
  logic [5:0] gain [2];
  int fails = 0;
  int n_compared = 0;
  int appl_cnt = 0;
  int abits = 8;
  logic [7:0] ash = 8'h00;
  logic scl_q = 1'b1;
  logic sda_q = 1'b1;
  amp_if bus ();
  amp_if bus_rd ();
  always #5 clk = ~clk;
  // masters run at their default divider so the bus stays within its rate limit
  amp_master i_amp_master (.clk(clk), .rst_b(rst_b), .bus(bus.master), .cmd_valid(cmd_valid[0]),
    .cmd_data(cmd_data), .cmd_last(cmd_last), .cmd_ready(rdy[0]), .done(done[0]), .nack(nack[0]));
  amp_master #(.ADDR_BYTE(8'hdf)) i_amp_master_rd (.clk(clk), .rst_b(rst_b), .bus(bus_rd.master),
    .cmd_valid(cmd_valid[1]), .cmd_data(cmd_data), .cmd_last(cmd_last), .cmd_ready(rdy[1]), .done(done[1]),
    .nack(nack[1]));
  amp_slave i_amp_slave (.clk(clk), .rst_b(rst_b), .bus(bus.slave), .power_active_bit(pwr[0]), .output_mute(mute[0]),
    .factory_test_bit(tst[0]), .gain_code(gain[0]), .output_muted(muted[0]), .selected(sel[0]), .byte_applied(appl[0]));
  amp_slave i_amp_slave_rd (.clk(clk), .rst_b(rst_b), .bus(bus_rd.slave), .power_active_bit(pwr[1]),
    .output_mute(mute[1]), .factory_test_bit(tst[1]), .gain_code(gain[1]), .output_muted(muted[1]),
    .selected(sel[1]), .byte_applied(appl[1]));
  amp_link_chk i_amp_link_chk (.clk(clk), .rst_b(rst_b), .scl(bus.scl), .sda_m_out(bus.sda_m_out),
    .sda_m_oe(bus.sda_m_oe), .sda_s_out(bus.sda_s_out), .sda_s_oe(bus.sda_s_oe), .sda(bus.sda));
  // captures the first byte after each start, sampled on clock rise
  always @(posedge clk) begin
    appl_cnt <= appl_cnt + int'(appl[0] === 1'b1);
    scl_q <= bus.scl;
    sda_q <= bus.sda;
    if (scl_q && bus.scl && sda_q && !bus.sda) begin
      abits <= 0;
    end else if (!scl_q && bus.scl && abits < 8) begin
      ash <= {ash[6:0], bus.sda};
      abits <= abits + 1;
    end
  end
  task check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fails++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task wait_ready(input int w);
    int n;
    n = 0;
    while (rdy[w] !== 1'b1 && n < 8000) begin
      @(negedge clk);
      n++;
    end
    check("ready", {7'h00, rdy[w]}, 8'h01);
  endtask
  task send(input int w, input logic [7:0] b, input logic last);
    @(negedge clk);
    cmd_valid[w] = 1'b1;
    cmd_data = b;
    cmd_last = last;
    wait_ready(w);
    @(negedge clk);
    cmd_valid[w] = 1'b0;
  endtask
  task write(input int w, input logic [7:0] b);
    send(w, b, 1'b1);
    wait_ready(w);
    check("done", {7'h00, done[w]}, 8'h01);
  endtask
  task expect_regs(input int w, input logic p, input logic m, input logic t, input logic [5:0] g, input logic mu);
    check("power", {7'h00, pwr[w]}, {7'h00, p});
    check("mute", {7'h00, mute[w]}, {7'h00, m});
    check("test", {7'h00, tst[w]}, {7'h00, t});
    check("gain", {2'b00, gain[w]}, {2'b00, g});
    check("muted", {7'h00, muted[w]}, {7'h00, mu});
  endtask
  task do_reset;
    rst_b = 1'b0;
    repeat (4) @(negedge clk);
    rst_b = 1'b1;
    repeat (5) @(negedge clk);
  endtask
  task end_sim;
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // a byte slot takes about 2250 cycles at the legal rate; whole run near 32000
  initial begin
    #600000;
    fails++;
    end_sim();
  end
  initial begin
    do_reset();
    expect_regs(0, 1'b0, 1'b0, 1'b0, 6'h00, 1'b1);
    write(0, 8'h01);
    expect_regs(0, 1'b1, 1'b0, 1'b0, 6'h00, 1'b1);
    check("addr", ash, amp_pkg::DEV_ADDR);
    check("nack", {7'h00, nack[0]}, 8'h00);
    check("applied", 8'(appl_cnt), 8'h01);
    send(0, 8'hc5, 1'b0);
    send(0, 8'h03, 1'b0);
    send(0, 8'h81, 1'b1);
    expect_regs(0, 1'b1, 1'b1, 1'b0, 6'h05, 1'b1);
    check("selected", {7'h00, sel[0]}, 8'h01);
    wait_ready(0);
    expect_regs(0, 1'b1, 1'b1, 1'b0, 6'h01, 1'b1);
    check("applied", 8'(appl_cnt), 8'h04);
    write(0, 8'h01);
    expect_regs(0, 1'b1, 1'b0, 1'b0, 6'h01, 1'b0);
    check("selected", {7'h00, sel[0]}, 8'h00);
    write(0, 8'h80);
    expect_regs(0, 1'b1, 1'b0, 1'b0, 6'h00, 1'b1);
    write(1, 8'h81);
    check("nack rd", {7'h00, nack[1]}, 8'h01);
    expect_regs(1, 1'b0, 1'b0, 1'b0, 6'h00, 1'b1);
    check("selected rd", {7'h00, sel[1]}, 8'h00);
    write(0, 8'hbf);
    expect_regs(0, 1'b1, 1'b0, 1'b0, 6'h3f, 1'b0);
    do_reset();
    expect_regs(0, 1'b0, 1'b0, 1'b0, 6'h00, 1'b1);
    end_sim();
  end
endmodule // test_amp_ctrl_i2c_write_slave
